// ==== hw/sop_servo_stage.sv ====
// Servo output stage: offsets, phase mapping and PID proportional/derivative terms
`timescale 1ns/1ps
// How it works
// RULE_01: Without commutation, first offset is added to the single command output.
// RULE_02: Sign-magnitude mode adds first offset before absolute value, second after.
// RULE_03: Commutating, loop address zero: offsets added to phase A and B commands.
// RULE_04: Variant 0 puts phase A on high DAC; variant 1 on A-channel.
// RULE_05: Offsets are signed 16-bit units, scaled up to the 18-bit DAC.
// RULE_06: Loop address nonzero: offsets added to ADC pair at address minus one.
// RULE_07: ADC offsets in 16-bit units; 12-bit readings are multiplied by sixteen.
// RULE_08: Output term is proportional gain times commanded minus actual position.
// RULE_09: Negative gain inverts output, or flips commutation angle 180 degrees.
// RULE_10: Derivative gain times measured velocity is subtracted from the output.
// RULE_11: Gains may be written anytime; next servo update uses them.
// RULE_12: Terms scaled by position and velocity scale factors, truncated to output width.
module sop_servo_stage
    import sop_pkg::*;
#(
    parameter int SERVO_DIV = SERVO_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Servo feedback and commutation commands
    input wire sop_pkg::sop_fb_t fb,
    input wire logic signed [15:0] phase_cmd_a,
    input wire logic signed [15:0] phase_cmd_b,
    input wire sop_pkg::sop_adc_pair_t [sop_pkg::ADC_PAIRS-1:0] adc,
    // Amplifier and current loop outputs
    output sop_pkg::sop_dac_t dac,
    output logic signed [15:0] ctrl_out,
    output logic signed [15:0] cur_fb_a,
    output logic signed [15:0] cur_fb_b,
    output logic phase_flip,
    output logic servo_tick
);
    import sop_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_m_q;
    logic rst_s_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic comm_en_q;
    logic variant_q;
    logic [31:0] outcfg_q;
    logic signed [OFF_W-1:0] off1_q;
    logic signed [OFF_W-1:0] off2_q;
    logic [CLA_W-1:0] cla_q;
    logic signed [GAIN_W-1:0] kp_q;
    logic signed [GAIN_W-1:0] kd_q;
    logic [SCL_W-1:0] psf_q;
    logic [SCL_W-1:0] vsf_q;
    logic [15:0] upd_cnt_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rd_d;
    logic [31:0] rd_val;
    logic addr_ok;
    sop_state_t state_q;

    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Register writes land in the data phase; taken anytime
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            comm_en_q <= 1'b0;
            variant_q <= 1'b0;
            outcfg_q <= '0;
            off1_q <= '0;
            off2_q <= '0;
            cla_q <= '0;
            kp_q <= KP_RST;
            kd_q <= KD_RST;
            psf_q <= PSF_RST;
            vsf_q <= VSF_RST;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                A_COMM: begin
                    comm_en_q <= hwdata[COMM_EN_BIT];
                    variant_q <= hwdata[VARIANT_BIT];
                end
                A_OUTCFG: outcfg_q <= hwdata;
                A_OFF1: off1_q <= hwdata[OFF_W-1:0]; // see RULE_05
                A_OFF2: off2_q <= hwdata[OFF_W-1:0]; // see RULE_05
                A_CLA: cla_q <= hwdata[CLA_W-1:0];
                A_KP: kp_q <= hwdata[GAIN_W-1:0]; // see RULE_11
                A_KD: kd_q <= hwdata[GAIN_W-1:0]; // see RULE_11
                A_PSF: psf_q <= hwdata[SCL_W-1:0];
                A_VSF: vsf_q <= hwdata[SCL_W-1:0];
                default: ;
            endcase
        end
    end

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        unique case (a)
            A_COMM: read_mux = {30'h0, variant_q, comm_en_q};
            A_OUTCFG: read_mux = outcfg_q;
            A_OFF1: read_mux = {{16{off1_q[OFF_W-1]}}, off1_q};
            A_OFF2: read_mux = {{16{off2_q[OFF_W-1]}}, off2_q};
            A_CLA: read_mux = {24'h0, cla_q};
            A_KP: read_mux = {{8{kp_q[GAIN_W-1]}}, kp_q};
            A_KD: read_mux = {{8{kd_q[GAIN_W-1]}}, kd_q};
            A_PSF: read_mux = {16'h0, psf_q};
            A_VSF: read_mux = {16'h0, vsf_q};
            A_STAT: read_mux = {upd_cnt_q, 12'h0, phase_flip, state_q != ST_IDLE, dac.dac_sign, 1'b0};
            A_CTRL_OUT: read_mux = {{16{ctrl_out[15]}}, ctrl_out};
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    // A write still in its data phase is forwarded to a read of the same word
    always_comb begin
        rd_val = read_mux(haddr[7:0]);
        if (wr_pend_q && wr_addr_q == haddr[7:0]) begin
            rd_val = hwdata;
        end
        rd_d = hrdata;
        if (addr_ok && !hwrite) begin
            rd_d = rd_val;
        end
    end

    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            hrdata <= '0;
        end else begin
            hrdata <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Servo update divider
    // ------------------------------------------------------------
    logic [31:0] div_q;

    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            div_q <= '0;
            servo_tick <= 1'b0;
        end else begin
            servo_tick <= (div_q == 32'(SERVO_DIV - 1));
            div_q <= (div_q == 32'(SERVO_DIV - 1)) ? '0 : div_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Update sequence and snapshot
    // ------------------------------------------------------------
    logic signed [GAIN_W-1:0] kp_s;
    logic signed [GAIN_W-1:0] kd_s;
    logic [SCL_W-1:0] psf_s;
    logic [SCL_W-1:0] vsf_s;
    logic signed [ERR_W-1:0] err_s;
    logic signed [GAIN_W-1:0] vel_s;
    logic signed [POS_W:0] err_full;

    assign err_full = {fb.cmd_pos[POS_W-1], fb.cmd_pos} - {fb.act_pos[POS_W-1], fb.act_pos}; // see RULE_08

    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: state_q <= servo_tick ? ST_MUL1 : ST_IDLE;
                ST_MUL1: state_q <= ST_MUL2;
                ST_MUL2: state_q <= ST_MUL3;
                ST_MUL3: state_q <= ST_OUT;
                ST_OUT: state_q <= ST_IDLE;
            endcase
        end
    end

    // Gains are sampled once per update so new values apply from the next one
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            kp_s <= '0;
            kd_s <= '0;
            psf_s <= '0;
            vsf_s <= '0;
            err_s <= '0;
            vel_s <= '0;
        end else if (state_q == ST_IDLE && servo_tick) begin
            kp_s <= kp_q; // see RULE_11
            kd_s <= kd_q; // see RULE_11
            psf_s <= psf_q;
            vsf_s <= vsf_q;
            err_s <= err_full[ERR_W-1:0];
            vel_s <= fb.meas_vel;
        end
    end

    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            upd_cnt_q <= '0;
        end else if (state_q == ST_OUT) begin
            upd_cnt_q <= upd_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Proportional and derivative terms
    // ------------------------------------------------------------
    logic signed [47:0] p1;
    logic signed [47:0] d1;
    logic signed [31:0] p2;
    logic signed [47:0] d2;
    logic signed [31:0] d3;
    logic signed [31:0] ctrl_sum;

    sop_mul #(.AW(GAIN_W), .BW(ERR_W), .SH(0), .QW(48)) u_p1 (
        .clk(clk), .rst_n(rst_s_q), .en(state_q == ST_MUL1),
        .a(kp_s), .b(err_s), .q(p1)); // see RULE_08
    sop_mul #(.AW(GAIN_W), .BW(GAIN_W), .SH(0), .QW(48)) u_d1 (
        .clk(clk), .rst_n(rst_s_q), .en(state_q == ST_MUL1),
        .a(kd_s), .b(vel_s), .q(d1)); // see RULE_10
    sop_mul #(.AW(48), .BW(SCL_W + 1), .SH(P_SH), .QW(32)) u_p2 (
        .clk(clk), .rst_n(rst_s_q), .en(state_q == ST_MUL2),
        .a(p1), .b({1'b0, psf_s}), .q(p2)); // see RULE_12
    sop_mul #(.AW(48), .BW(SCL_W + 1), .SH(0), .QW(48)) u_d2 (
        .clk(clk), .rst_n(rst_s_q), .en(state_q == ST_MUL2),
        .a(d1), .b({1'b0, vsf_s}), .q(d2)); // see RULE_12
    sop_mul #(.AW(48), .BW(GAIN_W), .SH(D_SH), .QW(32)) u_d3 (
        .clk(clk), .rst_n(rst_s_q), .en(state_q == ST_MUL3),
        .a(d2), .b(kp_s), .q(d3)); // see RULE_12

    // Sign of the gain carries straight through, inverting the output
    assign ctrl_sum = p2 - d3; // see RULE_10, RULE_09

    // ------------------------------------------------------------
    // Offsets and output mapping
    // ------------------------------------------------------------
    logic signed [15:0] cmd_new;
    logic signed [DAC_W-1:0] dac_single;
    logic signed [DAC_W-1:0] dac_pa;
    logic signed [DAC_W-1:0] dac_pb;
    logic signed [OFF_W:0] sm_pre;
    logic signed [OFF_W:0] sm_abs;
    logic signed [DAC_W-1:0] dac_mag;
    logic signed [15:0] cur_a;
    logic signed [15:0] cur_b;
    logic signed [15:0] pa_off;
    logic signed [15:0] pb_off;
    logic cl_on;
    logic sign_mag;
    logic [CLA_W-1:0] adc_idx;
    sop_adc_pair_t adc_sel;

    assign cmd_new = ctrl_sum[15:0]; // see RULE_12
    assign cl_on = cla_q != '0;
    assign sign_mag = outcfg_q[SIGN_MAG_BIT];
    assign pa_off = cl_on ? 16'sh0000 : off1_q; // see RULE_03
    assign pb_off = cl_on ? 16'sh0000 : off2_q; // see RULE_03
    assign adc_idx = cla_q - 8'h01; // see RULE_06
    assign adc_sel = (cl_on && adc_idx < CLA_W'(ADC_PAIRS)) ? adc[adc_idx[1:0]] : '0;
    assign sm_pre = {cmd_new[15], cmd_new} + {off1_q[OFF_W-1], off1_q}; // see RULE_02
    assign sm_abs = sop_abs(sm_pre); // see RULE_02

    sop_offset_add #(.IW(16), .VSH(DAC_SH), .OSH(DAC_SH), .OW(DAC_W)) u_off_single (
        .val(cmd_new), .off(off1_q), .sum(dac_single)); // see RULE_01, RULE_05
    sop_offset_add #(.IW(17), .VSH(DAC_SH), .OSH(DAC_SH), .OW(DAC_W)) u_off_mag (
        .val(sm_abs), .off(off2_q), .sum(dac_mag)); // see RULE_02
    sop_offset_add #(.IW(16), .VSH(DAC_SH), .OSH(DAC_SH), .OW(DAC_W)) u_off_pa (
        .val(phase_cmd_a), .off(pa_off), .sum(dac_pa)); // see RULE_03, RULE_05
    sop_offset_add #(.IW(16), .VSH(DAC_SH), .OSH(DAC_SH), .OW(DAC_W)) u_off_pb (
        .val(phase_cmd_b), .off(pb_off), .sum(dac_pb)); // see RULE_03, RULE_05
    sop_offset_add #(.IW(ADC_W), .VSH(ADC_SH), .OSH(0), .OW(16)) u_off_ca (
        .val(adc_sel.phase_a), .off(off1_q), .sum(cur_a)); // see RULE_06, RULE_07
    sop_offset_add #(.IW(ADC_W), .VSH(ADC_SH), .OSH(0), .OW(16)) u_off_cb (
        .val(adc_sel.phase_b), .off(off2_q), .sum(cur_b)); // see RULE_06, RULE_07

    // Control output and amplifier commands are written on each update
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            ctrl_out <= '0;
            dac <= '0;
            phase_flip <= 1'b0;
        end else if (state_q == ST_OUT) begin
            ctrl_out <= cmd_new;
            phase_flip <= comm_en_q && kp_s[GAIN_W-1]; // see RULE_09
            if (!comm_en_q && sign_mag) begin
                dac.dac_lo <= dac_mag; // see RULE_02
                dac.dac_hi <= '0;
                dac.dac_sign <= sm_pre[OFF_W];
            end else if (!comm_en_q) begin
                dac.dac_lo <= dac_single; // see RULE_01
                dac.dac_hi <= '0;
                dac.dac_sign <= 1'b0;
            end else if (!variant_q) begin
                dac.dac_hi <= dac_pa; // see RULE_04
                dac.dac_lo <= dac_pb; // see RULE_04
                dac.dac_sign <= 1'b0;
            end else begin
                dac.dac_lo <= dac_pa; // see RULE_04
                dac.dac_hi <= dac_pb; // see RULE_04
                dac.dac_sign <= 1'b0;
            end
        end
    end

    // Current feedback sums follow the ADC every cycle while commutating with the loop closed
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            cur_fb_a <= '0;
            cur_fb_b <= '0;
        end else begin
            cur_fb_a <= (comm_en_q && cl_on) ? cur_a : 16'sh0000; // see RULE_06
            cur_fb_b <= (comm_en_q && cl_on) ? cur_b : 16'sh0000; // see RULE_06
        end
    end
endmodule : sop_servo_stage

// ==== hw/sop_pkg.sv ====
// Shared constants, types and helpers for the servo offset and PID stage
package sop_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int OFF_W = 16;
    localparam int GAIN_W = 24;
    localparam int SCL_W = 16;
    localparam int POS_W = 32;
    localparam int ERR_W = 24;
    localparam int CMD_W = 16;
    localparam int DAC_W = 18;
    localparam int ADC_W = 12;
    localparam int CLA_W = 8;
    localparam int ADC_PAIRS = 4;
    // Converter scaling against 16-bit units
    localparam int DAC_SH = DAC_W - OFF_W;
    localparam int ADC_SH = OFF_W - ADC_W;
    // Fixed-point shifts of the control terms
    localparam int P_SH = 19;
    localparam int D_SH = 26;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_COMM = 8'h00;
    localparam logic [7:0] A_OUTCFG = 8'h04;
    localparam logic [7:0] A_OFF1 = 8'h08;
    localparam logic [7:0] A_OFF2 = 8'h0C;
    localparam logic [7:0] A_CLA = 8'h10;
    localparam logic [7:0] A_KP = 8'h14;
    localparam logic [7:0] A_KD = 8'h18;
    localparam logic [7:0] A_PSF = 8'h1C;
    localparam logic [7:0] A_VSF = 8'h20;
    localparam logic [7:0] A_STAT = 8'h24;
    localparam logic [7:0] A_CTRL_OUT = 8'h28;
    // Field positions
    localparam int COMM_EN_BIT = 0;
    localparam int VARIANT_BIT = 1;
    localparam int SIGN_MAG_BIT = 16;
    // Reset values
    localparam logic [GAIN_W-1:0] KP_RST = 24'h0007D0;
    localparam logic [GAIN_W-1:0] KD_RST = 24'h000500;
    localparam logic [SCL_W-1:0] PSF_RST = 16'h0080;
    localparam logic [SCL_W-1:0] VSF_RST = 16'h0080;
    // Servo update timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SERVO_PERIOD_NS = 440000;
    localparam int SERVO_CYCLES = SERVO_PERIOD_NS / CLK_PERIOD_NS;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [POS_W-1:0] cmd_pos;
        logic signed [POS_W-1:0] act_pos;
        logic signed [GAIN_W-1:0] meas_vel;
    } sop_fb_t;
    typedef struct packed {
        logic signed [ADC_W-1:0] phase_a;
        logic signed [ADC_W-1:0] phase_b;
    } sop_adc_pair_t;
    typedef struct packed {
        logic signed [DAC_W-1:0] dac_hi;
        logic signed [DAC_W-1:0] dac_lo;
        logic dac_sign;
    } sop_dac_t;
    typedef enum logic [2:0] {ST_IDLE, ST_MUL1, ST_MUL2, ST_MUL3, ST_OUT} sop_state_t;

    function automatic logic signed [OFF_W:0] sop_abs(input logic signed [OFF_W:0] v);
        sop_abs = v[OFF_W] ? -v : v;
    endfunction : sop_abs
endpackage : sop_pkg

// ==== hw/sop_mul.sv ====
// Registered signed multiply with arithmetic right shift and truncation
`timescale 1ns/1ps
module sop_mul #(
    parameter int AW = 24,
    parameter int BW = 24,
    parameter int SH = 0,
    parameter int QW = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Operands
    input wire logic en,
    input wire logic signed [AW-1:0] a,
    input wire logic signed [BW-1:0] b,
    // Result
    output logic signed [QW-1:0] q
);
    logic signed [AW+BW-1:0] prod;
    logic signed [AW+BW-1:0] shifted;

    assign prod = a * b;
    assign shifted = prod >>> SH;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (en) begin
            q <= shifted[QW-1:0];
        end
    end
endmodule : sop_mul

// ==== hw/sop_offset_add.sv ====
// Scales a value and a 16-bit-unit offset to converter units, adds and saturates
`timescale 1ns/1ps
module sop_offset_add #(
    parameter int IW = 16,
    parameter int VSH = 2,
    parameter int OSH = 2,
    parameter int OW = 18
) (
    // Operands
    input wire logic signed [IW-1:0] val,
    input wire logic signed [15:0] off,
    // Result
    output logic signed [OW-1:0] sum
);
    localparam int SW = OW + 2;
    localparam logic signed [SW-1:0] MAXV = SW'((1 <<< (OW - 1)) - 1);
    localparam logic signed [SW-1:0] MINV = -MAXV - SW'(1);
    logic signed [SW-1:0] v_s;
    logic signed [SW-1:0] o_s;
    logic signed [SW-1:0] raw;

    assign v_s = SW'(val) <<< VSH;
    assign o_s = SW'(off) <<< OSH;
    assign raw = v_s + o_s;

    always_comb begin
        if (raw > MAXV) begin
            sum = MAXV[OW-1:0];
        end else if (raw < MINV) begin
            sum = MINV[OW-1:0];
        end else begin
            sum = raw[OW-1:0];
        end
    end
endmodule : sop_offset_add

// ==== bench/sop_amp_model.sv ====
// Amplifier-side model: phase-current converters reading a standstill offset
`timescale 1ns/1ps
module sop_amp_model
    import sop_pkg::*;
(
    // Current readings per converter pair
    output sop_pkg::sop_adc_pair_t [sop_pkg::ADC_PAIRS-1:0] adc
);
    always_comb begin
        for (int i = 0; i < ADC_PAIRS; i++) begin
            // Zero current still reads a small 12-bit offset
            adc[i].phase_a = ADC_W'(-5 - i);
            adc[i].phase_b = ADC_W'(100 + i);
        end
    end
endmodule : sop_amp_model

// ==== bench/sop_servo_stage_checker.sv ====
// Concurrent checks on the ports of the servo offset and PID stage
`timescale 1ns/1ps
module sop_servo_stage_checker
    import sop_pkg::*;
#(
    parameter int SERVO_DIV = SERVO_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Servo outputs
    input wire sop_pkg::sop_dac_t dac,
    input wire logic signed [15:0] ctrl_out,
    input wire logic phase_flip,
    input wire logic servo_tick
);
    logic [15:0] gap_q;
    logic seen_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Cycles since the last servo update
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 16'h0000;
            seen_q <= 1'b0;
        end else begin
            gap_q <= servo_tick ? 16'h0000 : gap_q + 16'h0001;
            seen_q <= seen_q | servo_tick;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    ready_const_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    tick_gap_a: assert property (servo_tick && seen_q |-> gap_q == 16'(SERVO_DIV - 1))
        else $error("servo update spacing wrong");
    tick_pulse_a: assert property (servo_tick |=> !servo_tick [*8])
        else $error("servo tick longer than one cycle");
    ctrl_timing_a: assert property ($changed(ctrl_out) |-> $past(servo_tick, 5))
        else $error("control output moved off the update slot");
    dac_timing_a: assert property ($changed(dac) |-> $past(servo_tick, 5))
        else $error("converter command moved off the update slot");
    flip_timing_a: assert property ($changed(phase_flip) |-> $past(servo_tick, 5))
        else $error("phase flip moved off the update slot");
    dac_grid_a: assert property ((dac.dac_lo[1:0] == 2'b00 || dac.dac_lo == 18'h1FFFF)
        && (dac.dac_hi[1:0] == 2'b00 || dac.dac_hi == 18'h1FFFF)) else $error("command not in 16-bit steps");
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("read data changed without a read");
endmodule : sop_servo_stage_checker

bind sop_servo_stage sop_servo_stage_checker #(.SERVO_DIV(SERVO_DIV)) chk_i (.clk, .rst_n, .hsel, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .dac, .ctrl_out, .phase_flip, .servo_tick);

// ==== bench/testbench.sv ====
// Self-checking bench for the servo offset and PID stage
`timescale 1ns/1ps
module testbench;
    import sop_pkg::*;
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp, phase_flip, servo_tick;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic signed [15:0] pca, pcb, ctrl_out, cur_a, cur_b;
    sop_fb_t fb;
    sop_adc_pair_t [ADC_PAIRS-1:0] adc;
    sop_dac_t dac;
    int err_count, cmp_count;
    sop_servo_stage #(.SERVO_DIV(20)) uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .fb(fb), .phase_cmd_a(pca), .phase_cmd_b(pcb), .adc(adc), .dac(dac), .ctrl_out(ctrl_out),
        .cur_fb_a(cur_a), .cur_fb_b(cur_b), .phase_flip(phase_flip), .servo_tick(servo_tick));
    sop_amp_model amp (.adc(adc));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Waits until the outputs of the next servo update have landed
    task automatic upd();
        @(posedge clk);
        #1;
        while (servo_tick !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        repeat (5) @(posedge clk);
        #1;
    endtask : upd
    function automatic int ectl(longint kp, longint kd, longint err, longint vel);
        return int'(((kp * err * 128) >>> 19) - ((kd * vel * 128 * kp) >>> 26));
    endfunction : ectl
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] a [7] = '{A_KP, A_KD, A_PSF, A_VSF, A_OFF1, A_CTRL_OUT, 8'h40};
        logic [31:0] e [7] = '{32'h000007D0, 32'h00000500, 32'h00000080, 32'h00000080, 32'h0, 32'h0, 32'h0};
        ahb(1'b1, A_CTRL_OUT, 32'h00001234);
        ahb(1'b1, 8'h40, 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, a[i], 32'h0);
            chk("reg", rd, e[i]);
        end
        $display("Done: register defaults");
    endtask : t_regs
    task automatic t_pd();
        fb <= '{cmd_pos: 32'h0000044C, act_pos: 32'h000003E8, meas_vel: 24'h00000A};
        ahb(1'b1, A_KP, 32'h00001000);
        ahb(1'b1, A_KD, 32'h00000100);
        upd();
        chk("ctrl_out", 32'(ctrl_out), ectl(4096, 256, 100, 10));
        chk("dac_lo", 32'(dac.dac_lo), 4 * ectl(4096, 256, 100, 10));
        ahb(1'b0, A_CTRL_OUT, 32'h0);
        chk("ctrl_reg", rd, ectl(4096, 256, 100, 10));
        $display("Done: proportional and derivative");
    endtask : t_pd
    task automatic t_off();
        ahb(1'b1, A_OFF1, 32'hFFFFFFFB);
        upd();
        chk("dac_lo", 32'(dac.dac_lo), 4 * (ectl(4096, 256, 100, 10) - 5));
        chk("dac_hi", 32'(dac.dac_hi), 0);
        ahb(1'b1, A_OFF1, 32'h00007FFF);
        upd();
        chk("dac_sat", 32'(dac.dac_lo), 32'h0001FFFF);
        $display("Done: output offset");
    endtask : t_off
    task automatic t_sign();
        ahb(1'b1, A_OUTCFG, 32'h00010000);
        ahb(1'b1, A_OFF1, 32'hFFFFFFFB);
        ahb(1'b1, A_OFF2, 32'h00000003);
        ahb(1'b1, A_KP, 32'hFFFFF000);
        upd();
        chk("ctrl_neg", 32'(ctrl_out), ectl(-4096, 256, 100, 10));
        chk("dac_mag", 32'(dac.dac_lo), 4 * (-(ectl(-4096, 256, 100, 10) - 5) + 3));
        chk("dac_sign", 32'(dac.dac_sign), 1);
        chk("flip_off", 32'(phase_flip), 0);
        ahb(1'b1, A_OUTCFG, 32'h0);
        $display("Done: sign and magnitude");
    endtask : t_sign
    task automatic t_comm();
        pca <= 16'h03E8;
        pcb <= 16'hF830;
        ahb(1'b1, A_OFF1, 32'h00000007);
        ahb(1'b1, A_OFF2, 32'hFFFFFFFD);
        for (int v = 0; v < 2; v++) begin
            ahb(1'b1, A_COMM, {30'h0, v[0], 1'b1});
            upd();
            chk("dac_hi", 32'(dac.dac_hi), v ? 4 * (-2000 - 3) : 4 * (1000 + 7));
            chk("dac_lo", 32'(dac.dac_lo), v ? 4 * (1000 + 7) : 4 * (-2000 - 3));
            chk("flip_on", 32'(phase_flip), 1);
        end
        $display("Done: commutated outputs");
    endtask : t_comm
    task automatic t_cur();
        ahb(1'b1, A_COMM, 32'h00000001);
        ahb(1'b1, A_OFF1, 32'h00000050);
        ahb(1'b1, A_OFF2, 32'hFFFFFFF0);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, A_CLA, 32'(i + 1));
            repeat (2) @(posedge clk);
            #1;
            chk("cur_a", 32'(cur_a), i < 4 ? (-5 - i) * 16 + 80 : 80);
            chk("cur_b", 32'(cur_b), i < 4 ? (100 + i) * 16 - 16 : -16);
        end
        upd();
        chk("dac_raw", 32'(dac.dac_hi), 4 * 1000);
        $display("Done: current feedback");
    endtask : t_cur
    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        err_count = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        fb = '0;
        pca = 16'h0000;
        pcb = 16'h0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_pd();
        t_off();
        t_sign();
        t_comm();
        t_cur();
        final_report();
    end
endmodule : testbench
